// >>> rtl/tx_power_and_synth_cal_regs.sv
// tx power table stepping and synth calibration registers over axi4-lite
module tx_power_and_synth_cal_regs #(
  parameter int STEP_DIV = tx_synth_cfg_pkg::RAMP_STEP_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tx_synth_cfg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [tx_synth_cfg_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [tx_synth_cfg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [tx_synth_cfg_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // modem side, same clock
  input wire logic tx_active_i,
  input wire logic tx_symbol_i,
  // calibration engine results, same clock
  input wire logic cal_done_i,
  input wire logic [3:0] cp_result_i,
  input wire logic [4:0] vco_result_i,
  input wire logic [5:0] cap_result_i,
  // power amplifier drive
  output logic pa_enable_o,
  output logic [tx_synth_cfg_pkg::REG_W-1:0] pa_setting_o,
  output logic [tx_synth_cfg_pkg::PT_IDX_W-1:0] pa_index_o,
  // analog settings
  output logic [tx_synth_cfg_pkg::REG_W-1:0] tx_front_end_config_o,
  output logic [tx_synth_cfg_pkg::REG_W-1:0] synth_charge_pump_cal_o,
  output logic [tx_synth_cfg_pkg::REG_W-1:0] synth_vco_current_cal_o,
  output logic [tx_synth_cfg_pkg::REG_W-1:0] synth_cap_array_cal_o,
  output logic [tx_synth_cfg_pkg::REG_W-1:0] synth_cal_control_o,
  output logic [tx_synth_cfg_pkg::REG_W-1:0] rc_osc_config_high_o
);
  import tx_synth_cfg_pkg::*;

  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [IDX_W-1:0] idx
  );
    reg_hit = (addr[ADDR_W-1:2] == idx);
  endfunction

  function automatic logic pt_hit(input logic [ADDR_W-1:0] addr);
    pt_hit = (addr[ADDR_W-1:2+PT_IDX_W] == IDX_PT_BASE[IDX_W-1:PT_IDX_W]);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic [REG_W-1:0] tx_front_end_config;
  logic [REG_W-1:0] synth_charge_pump_cal;
  logic [REG_W-1:0] synth_vco_current_cal;
  logic [REG_W-1:0] synth_cap_array_cal;
  logic [REG_W-1:0] synth_cal_control;
  logic [REG_W-1:0] rc_osc_config_high;
  logic [REG_W-1:0] tx_mode;
  logic [REG_W-1:0] amp_power_table [PT_DEPTH];

  // write channel holding state
  logic [ADDR_W-1:0] aw_addr;
  logic [REG_W-1:0] w_data;
  logic w_lane0;
  logic wr_fire;
  logic wr_en;
  logic wr_known;

  // ramp state
  ramp_state_t state;
  ramp_state_t next_state;
  logic [PT_IDX_W-1:0] cur_idx;
  logic [PT_IDX_W-1:0] next_idx;
  logic [PT_IDX_W-1:0] target_idx;
  logic [PT_IDX_W-1:0] power_select_index;
  logic ask_mode;
  logic step;
  logic [$clog2(STEP_DIV+1)-1:0] div_cnt;

  //////////////////////////////////////////////////////////////////////////
  // write decode
  // both halves latched and response slot free
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  // only byte lane 0 carries the 8-bit registers
  assign wr_en = wr_fire && w_lane0;

  wire hit_fe = reg_hit(aw_addr, IDX_FRONT_END);
  wire hit_cp = reg_hit(aw_addr, IDX_CP_CAL);
  wire hit_vco = reg_hit(aw_addr, IDX_VCO_CAL);
  wire hit_cap = reg_hit(aw_addr, IDX_CAP_CAL);
  wire hit_cc = reg_hit(aw_addr, IDX_CAL_CTRL);
  wire hit_rc = reg_hit(aw_addr, IDX_RC_CFG);
  wire hit_mode = reg_hit(aw_addr, IDX_TX_MODE);
  wire hit_pt = pt_hit(aw_addr);
  wire [PT_IDX_W-1:0] wr_pt_sel = aw_addr[2+PT_IDX_W-1:2];
  // status is read only; writes to it are accepted and dropped
  assign wr_known = hit_fe || hit_cp || hit_vco || hit_cap || hit_cc
    || hit_rc || hit_mode || hit_pt
    || reg_hit(aw_addr, IDX_TX_STATUS);

  //////////////////////////////////////////////////////////////////////////
  // axi write handshake
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_lane0 <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata[REG_W-1:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration registers; masks keep reserved bits at zero
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      tx_front_end_config <= RST_FRONT_END; // see R05
      synth_cal_control <= RST_CAL_CTRL; // see R13
      rc_osc_config_high <= RST_RC_CFG;
      tx_mode <= RST_TX_MODE;
    end
    else if (wr_en)
    begin
      if (hit_fe)
        tx_front_end_config <= w_data & MSK_FRONT_END; // see R14
      if (hit_cc)
        synth_cal_control <= w_data & MSK_CAL_CTRL; // see R13
      if (hit_rc)
        rc_osc_config_high <= w_data & MSK_RC_CFG;
      if (hit_mode)
        tx_mode <= w_data & MSK_TX_MODE;
    end
  end

  // calibration results: engine loads them, a bus write wins
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      synth_charge_pump_cal <= RST_CP_CAL; // see R06 R07 R08
      synth_vco_current_cal <= RST_VCO_CAL; // see R10 R11
      synth_cap_array_cal <= RST_CAP_CAL; // see R12
    end
    else
    begin
      if (wr_en && hit_cp)
        synth_charge_pump_cal <= w_data & MSK_CP_CAL; // see R09
      else if (cal_done_i)
        synth_charge_pump_cal[CP_RES_LSB+:4] <= cp_result_i; // see R08
      if (wr_en && hit_vco)
        synth_vco_current_cal <= w_data & MSK_VCO_CAL; // see R11
      else if (cal_done_i)
        synth_vco_current_cal[VCO_RES_LSB+:5] <= vco_result_i; // see R11
      if (wr_en && hit_cap)
        synth_cap_array_cal <= w_data & MSK_CAP_CAL; // see R09
      else if (cal_done_i)
        synth_cap_array_cal[5:0] <= cap_result_i; // see R12
    end
  end

  // power table entries
  generate
    for (genvar i = 0; i < PT_DEPTH; i++)
    begin : g_pt
      always_ff @(posedge clk_sys_i)
      begin
        if (sys_rst_i)
          amp_power_table[i] <= RST_PT;
        else if (wr_en && hit_pt && wr_pt_sel == PT_IDX_W'(i))
          amp_power_table[i] <= w_data & MSK_PT; // see R01
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // read path, one cycle after the address is taken
  wire [PT_IDX_W-1:0] rd_pt_sel = s_axi_araddr[2+PT_IDX_W-1:2];
  wire [REG_W-1:0] status_word = {2'h0, state, 1'b0, cur_idx};
  wire rd_pt = pt_hit(s_axi_araddr);
  wire rd_fe = reg_hit(s_axi_araddr, IDX_FRONT_END);
  wire rd_cp = reg_hit(s_axi_araddr, IDX_CP_CAL);
  wire rd_vco = reg_hit(s_axi_araddr, IDX_VCO_CAL);
  wire rd_cap = reg_hit(s_axi_araddr, IDX_CAP_CAL);
  wire rd_cc = reg_hit(s_axi_araddr, IDX_CAL_CTRL);
  wire rd_rc = reg_hit(s_axi_araddr, IDX_RC_CFG);
  wire rd_mode = reg_hit(s_axi_araddr, IDX_TX_MODE);
  wire rd_stat = reg_hit(s_axi_araddr, IDX_TX_STATUS);
  wire rd_known = rd_pt || rd_fe || rd_cp || rd_vco || rd_cap || rd_cc
    || rd_rc || rd_mode || rd_stat;
  wire [REG_W-1:0] rd_value =
    rd_pt ? amp_power_table[rd_pt_sel] :
    rd_fe ? tx_front_end_config :
    rd_cp ? synth_charge_pump_cal :
    rd_vco ? synth_vco_current_cal :
    rd_cap ? synth_cap_array_cal :
    rd_cc ? synth_cal_control :
    rd_rc ? rc_osc_config_high :
    rd_mode ? tx_mode :
    rd_stat ? status_word : 8'h00;

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {{(DATA_W-REG_W){1'b0}}, rd_value}; // see R14
      s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power step divider; one step per period keeps ramps slow enough for
  // the pa to settle without spectral splatter
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      div_cnt <= '0;
      step <= 1'b0;
    end
    else if (div_cnt == ($bits(div_cnt))'(STEP_DIV - 1))
    begin
      div_cnt <= '0;
      step <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 1'b1;
      step <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power ramp and keying
  assign power_select_index = tx_front_end_config[PWR_SEL_LSB+:PT_IDX_W];
  assign ask_mode = tx_mode[ASK_MODE_BIT];
  // keyed zero aims at entry zero, a one at the selected entry
  assign target_idx = (ask_mode && !tx_symbol_i) ? '0 // see R03
    : power_select_index; // see R01 R02

  always_comb
  begin
    next_state = state;
    next_idx = cur_idx;
    case (state)
      ST_IDLE:
      begin
        next_idx = '0;
        if (tx_active_i)
          next_state = ST_RAMP_UP;
      end
      ST_RAMP_UP:
      begin
        if (!tx_active_i)
          next_state = ST_RAMP_DOWN;
        else if (step && cur_idx < power_select_index)
          next_idx = cur_idx + 1'b1; // see R04
        else if (cur_idx >= power_select_index)
          next_state = ST_ON;
      end
      ST_ON:
      begin
        // the index walks one entry per step, which shapes keyed symbols
        if (!tx_active_i)
          next_state = ST_RAMP_DOWN;
        else if (step && cur_idx < target_idx)
          next_idx = cur_idx + 1'b1; // see R04
        else if (step && cur_idx > target_idx)
          next_idx = cur_idx - 1'b1; // see R04
      end
      ST_RAMP_DOWN:
      begin
        // a new frame waits until the ramp reaches zero
        if (cur_idx == '0)
          next_state = ST_IDLE;
        else if (step)
          next_idx = cur_idx - 1'b1; // see R04
      end
      default:
      begin
        next_state = ST_IDLE;
        next_idx = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      state <= ST_IDLE;
      cur_idx <= '0;
      pa_enable_o <= 1'b0;
      pa_index_o <= '0;
      pa_setting_o <= '0;
    end
    else
    begin
      state <= next_state;
      cur_idx <= next_idx;
      pa_enable_o <= (next_state != ST_IDLE);
      pa_index_o <= next_idx;
      pa_setting_o <= amp_power_table[next_idx]; // see R01
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // analog outputs straight from the registers
  assign tx_front_end_config_o = tx_front_end_config; // see R05
  assign synth_charge_pump_cal_o = synth_charge_pump_cal; // see R07
  assign synth_vco_current_cal_o = synth_vco_current_cal; // see R10
  assign synth_cap_array_cal_o = synth_cap_array_cal;
  assign synth_cal_control_o = synth_cal_control;
  assign rc_osc_config_high_o = rc_osc_config_high;

endmodule // tx_power_and_synth_cal_regs

// >>> rtl/tx_synth_cfg_pkg.sv
// constants, register map and types of the tx power and synth cal registers
//
// Overview of operation
// R01: A 3-bit power select field indexes an eight-entry power table.
// R02: In amplitude keying a one symbol uses the entry chosen by power select.
// R03: In amplitude keying a zero symbol uses power table entry zero.
// R04: Power steps through entries zero up to power select to ramp up and down and to shape keyed symbols.
// R05: A 2-bit tx LO buffer current field resets to 1 and sets the buffer current.
// R06: A 2-bit synth cal configuration field resets to 2 and is loaded by software before calibration.
// R07: A 2-bit field resets to 2 and enables the charge pump calibration stage.
// R08: A 4-bit charge pump current result resets to 1001 and sets the current on an exponential scale.
// R09: The three cal result registers are read-write so software can save and restore them per hop.
// R10: One bit picks the high vco core when set and the low one when clear, reset zero.
// R11: A 5-bit vco current result resets to 0x0A and a software write overrides it.
// R12: A 6-bit cap array result resets to 0x20.
// R13: A 7-bit synth cal control field resets to 0x0D.
// R14: Reserved bits read zero and ignore writes.
package tx_synth_cfg_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int IDX_W = ADDR_W - 2;
  localparam int REG_W = 8;
  localparam int PT_DEPTH = 8;
  localparam int PT_IDX_W = 3;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FRONT_END = 10'h022;
  localparam logic [IDX_W-1:0] IDX_CP_CAL = 10'h023;
  localparam logic [IDX_W-1:0] IDX_VCO_CAL = 10'h024;
  localparam logic [IDX_W-1:0] IDX_CAP_CAL = 10'h025;
  localparam logic [IDX_W-1:0] IDX_CAL_CTRL = 10'h026;
  localparam logic [IDX_W-1:0] IDX_RC_CFG = 10'h027;
  localparam logic [IDX_W-1:0] IDX_PT_BASE = 10'h040;
  localparam logic [IDX_W-1:0] IDX_TX_MODE = 10'h048;
  localparam logic [IDX_W-1:0] IDX_TX_STATUS = 10'h049;
  // reset values
  localparam logic [REG_W-1:0] RST_FRONT_END = 8'h10;
  localparam logic [REG_W-1:0] RST_CP_CAL = 8'hA9;
  localparam logic [REG_W-1:0] RST_VCO_CAL = 8'h0A;
  localparam logic [REG_W-1:0] RST_CAP_CAL = 8'h20;
  localparam logic [REG_W-1:0] RST_CAL_CTRL = 8'h0D;
  localparam logic [REG_W-1:0] RST_RC_CFG = 8'h41;
  localparam logic [REG_W-1:0] RST_PT = 8'h00;
  localparam logic [REG_W-1:0] RST_TX_MODE = 8'h00;
  // writable bit masks
  localparam logic [REG_W-1:0] MSK_FRONT_END = 8'h37;
  localparam logic [REG_W-1:0] MSK_CP_CAL = 8'hFF;
  localparam logic [REG_W-1:0] MSK_VCO_CAL = 8'h3F;
  localparam logic [REG_W-1:0] MSK_CAP_CAL = 8'h3F;
  localparam logic [REG_W-1:0] MSK_CAL_CTRL = 8'h7F;
  localparam logic [REG_W-1:0] MSK_RC_CFG = 8'h7F;
  localparam logic [REG_W-1:0] MSK_PT = 8'hFF;
  localparam logic [REG_W-1:0] MSK_TX_MODE = 8'h01;
  // field positions
  localparam int PWR_SEL_LSB = 0;
  localparam int LO_BUF_LSB = 4;
  localparam int CP_RES_LSB = 0;
  localparam int CP_EN_LSB = 4;
  localparam int CAL_CFG_LSB = 6;
  localparam int VCO_RES_LSB = 0;
  localparam int VCO_HIGH_BIT = 5;
  localparam int ASK_MODE_BIT = 0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // power step timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_STEP_CYC = RAMP_STEP_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAMP_UP = 2'b01,
    ST_ON = 2'b10,
    ST_RAMP_DOWN = 2'b11
  } ramp_state_t;
endpackage

// >>> bench/tx_synth_cfg_asserts.sv
// assertion checker for the tx power and synth cal register block
module tx_synth_cfg_asserts #(
  parameter int STEP_DIV = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // modem and calibration
  input wire logic tx_active_i,
  input wire logic cal_done_i,
  input wire logic [3:0] cp_result_i,
  input wire logic [4:0] vco_result_i,
  input wire logic [5:0] cap_result_i,
  // outputs
  input wire logic pa_enable_o,
  input wire logic [2:0] pa_index_o,
  input wire logic [7:0] tx_front_end_config_o,
  input wire logic [7:0] synth_charge_pump_cal_o,
  input wire logic [7:0] synth_vco_current_cal_o,
  input wire logic [7:0] synth_cap_array_cal_o,
  input wire logic [7:0] synth_cal_control_o,
  input wire logic [7:0] rc_osc_config_high_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////////////////
  property p_reset_vals;
    $fell(sys_rst_i) |-> tx_front_end_config_o == 8'h10
      && synth_charge_pump_cal_o == 8'hA9 && synth_vco_current_cal_o == 8'h0A
      && synth_cap_array_cal_o == 8'h20 && synth_cal_control_o == 8'h0D;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("register not at reset value");
  property p_reserved;
    ((tx_front_end_config_o & 8'hC8) | (synth_vco_current_cal_o & 8'hC0)
      | (synth_cap_array_cal_o & 8'hC0) | (synth_cal_control_o & 8'h80)
      | (rc_osc_config_high_o & 8'h80)) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit set");
  property p_rdata_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper)
    else $error("read data upper bits set");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response not held");
  // a pending write wins over the load, so only check with the bus quiet
  property p_cal_load;
    cal_done_i && s_axi_awready |=>
      synth_charge_pump_cal_o[3:0] == $past(cp_result_i)
      && synth_vco_current_cal_o[4:0] == $past(vco_result_i)
      && synth_cap_array_cal_o[5:0] == $past(cap_result_i);
  endproperty
  a_cal_load: assert property (p_cal_load)
    else $error("calibration result not loaded");
  property p_start;
    tx_active_i && !pa_enable_o |=> pa_enable_o;
  endproperty
  a_start: assert property (p_start)
    else $error("ramp did not start");
  property p_idle_zero;
    !pa_enable_o |-> pa_index_o == 3'h0;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("index not zero while idle");
  property p_one_step;
    !$stable(pa_index_o) |-> pa_index_o == $past(pa_index_o) + 3'h1
      || pa_index_o == $past(pa_index_o) - 3'h1;
  endproperty
  a_one_step: assert property (p_one_step)
    else $error("index jumped");
endmodule // tx_synth_cfg_asserts

bind tx_power_and_synth_cal_regs tx_synth_cfg_asserts #(.STEP_DIV(STEP_DIV))
  u_asserts (.clk_sys_i, .sys_rst_i, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .tx_active_i, .cal_done_i, .cp_result_i,
  .vco_result_i, .cap_result_i, .pa_enable_o, .pa_index_o,
  .tx_front_end_config_o, .synth_charge_pump_cal_o, .synth_vco_current_cal_o,
  .synth_cap_array_cal_o, .synth_cal_control_o, .rc_osc_config_high_o);

// >>> bench/tb.sv
// self-checking bench for the tx power and synth cal register block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tx_synth_cfg_pkg::*;
  logic clk_sys_i, sys_rst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, tx_active_i, tx_symbol_i, cal_done_i;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot, pa_index_o;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, cp_result_i;
  logic [4:0] vco_result_i;
  logic [5:0] cap_result_i;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pa_enable_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] pa_setting_o, tx_front_end_config_o, synth_charge_pump_cal_o;
  logic [7:0] synth_vco_current_cal_o, synth_cap_array_cal_o;
  logic [7:0] synth_cal_control_o, rc_osc_config_high_o;
  logic [7:0] reg_o [6];
  logic [9:0] idx_l [6] = '{IDX_FRONT_END, IDX_CP_CAL, IDX_VCO_CAL,
    IDX_CAP_CAL, IDX_CAL_CTRL, IDX_RC_CFG};
  logic [7:0] rst_l [6] = '{8'h10, 8'hA9, 8'h0A, 8'h20, 8'h0D, 8'h41};
  logic [7:0] msk_l [6] = '{8'h37, 8'hFF, 8'h3F, 8'h3F, 8'h7F, 8'h7F};
  int fails = 0;
  int n_tests = 0;
  assign reg_o[0] = tx_front_end_config_o;
  assign reg_o[1] = synth_charge_pump_cal_o;
  assign reg_o[2] = synth_vco_current_cal_o;
  assign reg_o[3] = synth_cap_array_cal_o;
  assign reg_o[4] = synth_cal_control_o;
  assign reg_o[5] = rc_osc_config_high_o;
  ////////////////////////////////////////////////////////////////////////////
  tx_power_and_synth_cal_regs #(.STEP_DIV(4)) dut (.clk_sys_i, .sys_rst_i,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .tx_active_i, .tx_symbol_i, .cal_done_i, .cp_result_i,
    .vco_result_i, .cap_result_i, .pa_enable_o, .pa_setting_o, .pa_index_o,
    .tx_front_end_config_o, .synth_charge_pump_cal_o, .synth_vco_current_cal_o,
    .synth_cap_array_cal_o, .synth_cal_control_o, .rc_osc_config_high_o);
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // every wait is bounded; running out ends the run as a failure
  task automatic tick(inout int n);
    @(posedge clk_sys_i);
    n++;
    if (n > 200)
    begin
      fails++;
      tally_and_finish();
    end
  endtask

  function automatic logic [11:0] ba(input logic [9:0] i);
    return {i, 2'b00};
  endfunction

  function automatic logic [7:0] pte(input logic [2:0] i);
    return {1'b0, i, 1'b1, i};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
    input logic [3:0] s, input logic [1:0] er);
    int n;
    logic ad;
    logic wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'hA5C35A, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd))
    begin
      tick(n);
      if (!ad && s_axi_awready)
      begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready)
      begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do tick(n); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] ed,
    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do tick(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0, ed});
    chk(s_axi_rresp, er);
  endtask

  task automatic wait_pa(input logic [3:0] t);
    int n;
    n = 0;
    do tick(n); while ({pa_enable_o, pa_index_o} !== t);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i)
    if (pa_enable_o === 1'b1)
      chk(pa_setting_o, pte(pa_index_o));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  initial
  begin
    logic [2:0] s;
    sys_rst_i = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
      tx_active_i, tx_symbol_i, cal_done_i, s_axi_awaddr, s_axi_araddr,
      s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb, cp_result_i,
      vco_result_i, cap_result_i} = '0;
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    // reset value, masked ones, ignored strobe, then zero back
    for (int i = 0; i < 6; i++)
    begin
      rd(ba(idx_l[i]), rst_l[i], RESP_OKAY);
      chk(reg_o[i], rst_l[i]);
      wr(ba(idx_l[i]), 8'hFF, 4'h1, RESP_OKAY);
      rd(ba(idx_l[i]), msk_l[i], RESP_OKAY);
      chk(reg_o[i], msk_l[i]);
      wr(ba(idx_l[i]), 8'h00, 4'hE, RESP_OKAY);
      rd(ba(idx_l[i]), msk_l[i], RESP_OKAY);
      wr(ba(idx_l[i]), 8'h00, 4'h1, RESP_OKAY);
      rd(ba(idx_l[i]), 8'h00, RESP_OKAY);
    end
    // calibration load, then a saved value restored over it
    cal_done_i <= 1'b1;
    cp_result_i <= 4'h7;
    vco_result_i <= 5'h15;
    cap_result_i <= 6'h2A;
    @(posedge clk_sys_i);
    cal_done_i <= 1'b0;
    rd(ba(IDX_CP_CAL), 8'h07, RESP_OKAY);
    rd(ba(IDX_VCO_CAL), 8'h15, RESP_OKAY);
    rd(ba(IDX_CAP_CAL), 8'h2A, RESP_OKAY);
    wr(ba(IDX_VCO_CAL), 8'h2B, 4'h1, RESP_OKAY);
    rd(ba(IDX_VCO_CAL), 8'h2B, RESP_OKAY);
    chk(synth_vco_current_cal_o[5], 1'b1);
    // unmapped and read-only places
    rd(12'h000, 8'h00, RESP_SLVERR);
    wr(12'h000, 8'h5A, 4'h1, RESP_SLVERR);
    wr(ba(IDX_TX_STATUS), 8'hFF, 4'h1, RESP_OKAY);
    rd(ba(IDX_TX_STATUS), 8'h00, RESP_OKAY);
    // power table, keyed mode, then a ramp for every select value
    for (int i = 0; i < 8; i++)
      wr(ba(10'(IDX_PT_BASE + i)), pte(3'(i)), 4'h1, RESP_OKAY);
    rd(ba(10'(IDX_PT_BASE + 5)), pte(3'h5), RESP_OKAY);
    wr(ba(IDX_TX_MODE), 8'h01, 4'h1, RESP_OKAY);
    tx_symbol_i <= 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      s = 3'(k);
      wr(ba(IDX_FRONT_END), {5'h02, s}, 4'h1, RESP_OKAY);
      tx_active_i <= 1'b1;
      wait_pa({1'b1, s});
      repeat (8) @(posedge clk_sys_i);
      chk({pa_enable_o, pa_index_o}, {1'b1, s});
      rd(ba(IDX_TX_STATUS), {4'h2, 1'b0, s}, RESP_OKAY);
      tx_symbol_i <= 1'b0;
      wait_pa(4'h8);
      tx_symbol_i <= 1'b1;
      wait_pa({1'b1, s});
      tx_active_i <= 1'b0;
      wait_pa(4'h0);
    end
    // plain format: a zero symbol keeps the selected entry
    wr(ba(IDX_TX_MODE), 8'h00, 4'h1, RESP_OKAY);
    tx_symbol_i <= 1'b0;
    tx_active_i <= 1'b1;
    wait_pa({1'b1, s});
    repeat (8) @(posedge clk_sys_i);
    chk({pa_enable_o, pa_index_o}, {1'b1, s});
    tx_active_i <= 1'b0;
    wait_pa(4'h0);
    tally_and_finish();
  end
endmodule // tb
